// file: hw/swps_pkg.sv
/*
 Shared constants for the sleep/wake power sequencer: timing, pin bit
 positions, state and output encodings.
 Assumes a single 100 MHz always-on clock.
*/
package swps_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYC = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
   // Switch timing, counted in ticks
   localparam int HOLD_TIME_MS = 4000;
   localparam int HOLD_TICKS = HOLD_TIME_MS * 1000 / TICK_TIME_US;
   localparam int DEB_TIME_MS = 20;
   localparam int DEB_TICKS = DEB_TIME_MS * 1000 / TICK_TIME_US;
   // Reset and power-down phases, least times rounded up
   localparam int POR_TIME_US = 10;
   localparam int POR_CYC = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PD_TIME_US = 5;
   localparam int PD_CYC = (PD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PH_W = 10;
   // Suspend to RAM is not offered as a target
   localparam logic SUSP_RAM_EN = 1'b0;
   // Positions in the synchronised pin vector
   localparam int PIN_N = 15;
   localparam int P_RTC = 0;
   localparam int P_LAN = 1;
   localparam int P_MODEM = 2;
   localparam int P_THERM = 3;
   localparam int P_IR = 4;
   localparam int P_VOICE = 5;
   localparam int P_USB = 6;
   localparam int P_KBD = 7;
   localparam int P_MOUSE = 8;
   localparam int P_HSBUS = 9;
   localparam int P_SLPREQ = 10;
   localparam int P_SLPT0 = 11;
   localparam int P_SOFTOFF = 13;
   localparam int P_PFAIL = 14;
   // Requested sleep type
   localparam logic [1:0] REQ_S1 = 2'h1;
   localparam logic [1:0] REQ_S2 = 2'h2;
   localparam logic [1:0] REQ_S34 = 2'h3;
   // Reported sleeping state
   localparam logic [2:0] SLP_S0 = 3'h0;
   localparam logic [2:0] SLP_S1 = 3'h1;
   localparam logic [2:0] SLP_S2 = 3'h2;
   localparam logic [2:0] SLP_S34 = 3'h3;
   localparam logic [2:0] SLP_S5 = 3'h5;
   // Reported global state
   localparam logic [1:0] GLB_G0 = 2'h0;
   localparam logic [1:0] GLB_G1 = 2'h1;
   localparam logic [1:0] GLB_G2 = 2'h2;
   // Boot context after power-up
   localparam logic [1:0] BOOT_COLD = 2'h0;
   localparam logic [1:0] BOOT_RAM = 2'h1;
   localparam logic [1:0] BOOT_DISK = 2'h2;

   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_PWRUP = 3'b001,
      ST_WORK = 3'b011,
      ST_S1 = 3'b010,
      ST_S2 = 3'b110,
      ST_S34 = 3'b111,
      ST_PWRDN = 3'b101
   } swps_state_t;
endpackage : swps_pkg

// file: hw/swps_press.sv
/*
 Power switch front end: two-flop synchroniser, millisecond tick divider,
 debouncer and held-time counter that classifies presses.
 Assumes an active-low switch pin and the always-on clock.
*/
`timescale 1ns/10ps
module swps_press import swps_pkg::*; #(
   parameter int TICK_CYC_P = TICK_CYC
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // Switch pin
   input wire logic sw_n_in,
   // Classified presses
   output logic press_short_out,
   output logic press_long_out,
   output logic pressed_out
);
   localparam int TW = $clog2(TICK_CYC_P + 1);

   logic sw_m_q, sw_s_q;
   logic [TW-1:0] tick_cnt_q;
   logic [7:0] deb_cnt_q;
   logic deb_lvl_q;
   logic [12:0] hold_q;
   logic short_q, long_q;

   wire tick = (tick_cnt_q == TW'(TICK_CYC_P - 1));
   wire raw_pr = !sw_s_q;
   wire differs = (raw_pr != deb_lvl_q);
   wire deb_flip = differs && tick && (deb_cnt_q == 8'(DEB_TICKS - 1));
   wire hold_hit = deb_lvl_q && tick && (hold_q == 13'(HOLD_TICKS - 1));

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sw_m_q <= 1'b1;
         sw_s_q <= 1'b1;
      end else begin
         sw_m_q <= sw_n_in; // RULE_14
         sw_s_q <= sw_m_q;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
      end
   end

   // A bounce shorter than the debounce time restarts the count
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         deb_cnt_q <= '0;
         deb_lvl_q <= 1'b0;
      end else if (!differs || deb_flip) begin
         deb_cnt_q <= '0; // RULE_14
         deb_lvl_q <= deb_flip ? raw_pr : deb_lvl_q;
      end else if (tick) begin
         deb_cnt_q <= deb_cnt_q + 1'b1;
      end
   end

   // Held time saturates so a very long hold gives one long press only
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hold_q <= '0;
         short_q <= 1'b0;
         long_q <= 1'b0;
      end else begin
         short_q <= deb_flip && deb_lvl_q && (hold_q < 13'(HOLD_TICKS)); // RULE_14
         long_q <= hold_hit;
         if (!deb_lvl_q) begin
            hold_q <= '0;
         end else if (tick && hold_q < 13'(HOLD_TICKS)) begin
            hold_q <= hold_q + 1'b1;
         end
      end
   end

   assign press_short_out = short_q;
   assign press_long_out = long_q;
   assign pressed_out = deb_lvl_q;
endmodule : swps_press

// file: hw/swps_seq.sv
/*
 Sleep/wake power sequencer top: moves the board between working,
 sleeping and soft-off states from the power switch, wake pins and OS.
 Assumes all pins are asynchronous to core_clk_in and that the clock
 and the wake-up logic stay powered in every sleeping state.
*/
// Behaviour
// RULE_01 - Short switch press while off or sleeping brings system to working state.
// RULE_02 - Any switch press while working powers down to soft-off.
// RULE_03 - Switch, RTC alarm, LAN and modem wake from S1 through S5.
// RULE_04 - Thermal event wakes from S1, S2, S3/S4BIOS, ignored in S5.
// RULE_05 - IR, voice, USB, keyboard and mouse wake only from S1 or S2.
// RULE_06 - High-speed serial bus activity never wakes the system.
// RULE_07 - S1 holds the processor in stop-grant C1.
// RULE_08 - S2 holds the processor in clock-stopped C2.
// RULE_09 - Suspend to RAM is not offered as a target state.
// RULE_10 - S3 and S4BIOS entered together; resume from RAM, disk after power fail.
// RULE_11 - Leaving S5 always takes a cold boot with power-on reset.
// RULE_12 - S3/S4BIOS and S5 power only the wake-up logic.
// RULE_13 - OS soft-off request powers down to soft-off without the switch.
// RULE_14 - Switch is synchronised, debounced and its hold timed on the always-on clock.
`timescale 1ns/10ps
module swps_seq import swps_pkg::*; #(
   parameter int TICK_CYC_P = TICK_CYC
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // Front panel
   input wire logic pwr_sw_n_in,
   // Wake sources
   input wire logic rtc_alarm_in,
   input wire logic lan_wake_in,
   input wire logic modem_wake_in,
   input wire logic thermal_in,
   input wire logic ir_wake_in,
   input wire logic voice_wake_in,
   input wire logic usb_wake_in,
   input wire logic kbd_wake_in,
   input wire logic mouse_wake_in,
   input wire logic hs_bus_act_in,
   // Operating system requests and power fail
   input wire logic os_sleep_req_in,
   input wire logic [1:0] os_sleep_type_in,
   input wire logic os_soft_off_in,
   input wire logic pwr_fail_in,
   // Power and processor control
   output logic main_pwr_en_out,
   output logic wake_pwr_en_out,
   output logic por_n_out,
   output logic cpu_stop_grant_out,
   output logic cpu_clk_stop_out,
   // Status
   output logic [1:0] global_state_out,
   output logic [2:0] sleep_state_out,
   output logic [1:0] boot_mode_out,
   output logic wake_evt_out,
   output logic sleep_refused_out
);
   localparam int POR_BOUND = POR_CYC + 1;
   localparam int PD_BOUND = PD_CYC + 1;

   swps_state_t state_q, state_d;
   logic [PIN_N-1:0] pin_m_q, pin_s_q;
   logic req_d_q;
   logic [PH_W-1:0] ph_cnt_q;
   logic pf_q;
   logic [1:0] boot_q, boot_d;
   logic wake_q, refused_q;
   logic press_short, press_long;

   swps_press #(
      .TICK_CYC_P(TICK_CYC_P)
   ) u_press (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .sw_n_in(pwr_sw_n_in),
      .press_short_out(press_short),
      .press_long_out(press_long),
      .pressed_out()
   );

   wire [PIN_N-1:0] pin_raw = {pwr_fail_in, os_soft_off_in, os_sleep_type_in, os_sleep_req_in,
      hs_bus_act_in, mouse_wake_in, kbd_wake_in, usb_wake_in, voice_wake_in, ir_wake_in,
      thermal_in, modem_wake_in, lan_wake_in, rtc_alarm_in};

   // Two flops for every pin before any logic looks at it
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_m_q <= '0;
         pin_s_q <= '0;
         req_d_q <= 1'b0;
      end else begin
         pin_m_q <= pin_raw;
         pin_s_q <= pin_m_q;
         req_d_q <= pin_s_q[P_SLPREQ];
      end
   end

   // Wake qualification per depth of sleep
   wire core_wake = pin_s_q[P_RTC] | pin_s_q[P_LAN] | pin_s_q[P_MODEM]; // RULE_03
   wire therm_wake = pin_s_q[P_THERM];
   wire light_wake = |pin_s_q[P_MOUSE:P_IR];
   wire hs_bus_act = pin_s_q[P_HSBUS]; // RULE_06
   wire wake_s5 = press_short | core_wake; // RULE_03
   wire wake_s34 = wake_s5 | therm_wake; // RULE_04
   wire wake_s12 = wake_s34 | light_wake; // RULE_05
   // The serial bus pin feeds none of the wake terms above
   wire os_off = pin_s_q[P_SOFTOFF];
   wire pfail = pin_s_q[P_PFAIL];
   wire req_rise = pin_s_q[P_SLPREQ] && !req_d_q;
   wire [1:0] req_type = pin_s_q[P_SLPT0 +: 2];
   wire sw_any = press_short | press_long;
   wire ph_done = (ph_cnt_q == PH_W'(POR_CYC - 1));
   wire pd_done = (ph_cnt_q == PH_W'(PD_CYC - 1));
   wire s34_ok = (req_type == REQ_S34) && SUSP_RAM_EN; // RULE_09
   wire refuse = (state_q == ST_WORK) && !sw_any && !os_off && req_rise
      && ((req_type == REQ_S34 && !SUSP_RAM_EN) || req_type == 2'h0);
   wire deep = (state_q == ST_OFF) || (state_q == ST_S34);

   always_comb begin
      state_d = state_q;
      boot_d = boot_q;
      case (state_q)
         ST_OFF: begin
            if (wake_s5) begin
               state_d = ST_PWRUP; // RULE_11
               boot_d = BOOT_COLD; // RULE_11
            end
         end
         ST_PWRUP: begin
            if (ph_done) begin
               state_d = ST_WORK;
            end
         end
         ST_WORK: begin
            if (sw_any || os_off) begin
               state_d = ST_PWRDN; // RULE_02 RULE_13
            end else if (req_rise && req_type == REQ_S1) begin
               state_d = ST_S1;
            end else if (req_rise && req_type == REQ_S2) begin
               state_d = ST_S2;
            end else if (req_rise && s34_ok) begin
               state_d = ST_S34; // RULE_10
            end
         end
         ST_S1, ST_S2: begin
            if (wake_s12) begin
               state_d = ST_WORK; // RULE_01 RULE_05
            end
         end
         ST_S34: begin
            if (wake_s34) begin
               state_d = ST_PWRUP; // RULE_01 RULE_04
               boot_d = pf_q ? BOOT_DISK : BOOT_RAM; // RULE_10
            end
         end
         ST_PWRDN: begin
            if (pd_done) begin
               state_d = ST_OFF;
            end
         end
         default: begin
            state_d = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= ST_OFF;
         boot_q <= BOOT_COLD;
         ph_cnt_q <= '0;
      end else begin
         state_q <= state_d;
         boot_q <= boot_d;
         ph_cnt_q <= (state_d != state_q) ? '0 : ph_cnt_q + 1'b1;
      end
   end

   // Power loss seen while suspended forces the disk image; set beats clear
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pf_q <= 1'b0;
         wake_q <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         if (state_q == ST_S34 && pfail) begin
            pf_q <= 1'b1; // RULE_10
         end else if (state_q == ST_WORK) begin
            pf_q <= 1'b0;
         end
         wake_q <= (state_q != ST_WORK && state_q != ST_PWRUP && state_q != ST_PWRDN)
            && (state_d == ST_WORK || state_d == ST_PWRUP);
         refused_q <= refuse; // RULE_09
      end
   end

   // Output decode
   assign main_pwr_en_out = !deep; // RULE_12
   assign wake_pwr_en_out = 1'b1; // RULE_12
   assign por_n_out = !deep && (state_q != ST_PWRUP); // RULE_11
   assign cpu_stop_grant_out = (state_q == ST_S1); // RULE_07
   assign cpu_clk_stop_out = (state_q == ST_S2); // RULE_08
   assign global_state_out = (state_q == ST_WORK || state_q == ST_PWRUP) ? GLB_G0 :
      (state_q == ST_OFF || state_q == ST_PWRDN) ? GLB_G2 : GLB_G1;
   assign sleep_state_out = (state_q == ST_S1) ? SLP_S1 : (state_q == ST_S2) ? SLP_S2 :
      (state_q == ST_S34) ? SLP_S34 : (state_q == ST_OFF) ? SLP_S5 : SLP_S0;
   assign boot_mode_out = boot_q;
   assign wake_evt_out = wake_q;
   assign sleep_refused_out = refused_q;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence seq_por_phase;
      !por_n_out && state_q == ST_PWRUP;
   endsequence
   sequence seq_pd_done;
      state_q == ST_PWRDN ##[1:PD_BOUND] state_q == ST_OFF;
   endsequence
   sequence seq_boot_done;
      seq_por_phase ##[1:POR_BOUND] (state_q == ST_WORK && por_n_out);
   endsequence
   // Light sleep keeps power, so its exit is a single state step
   sequence seq_light_exit;
      state_q == ST_WORK ##0 wake_evt_out;
   endsequence

   chk_short_wake: assert property ( // RULE_01
      (state_q inside {ST_S1, ST_S2} && press_short) |=> state_q == ST_WORK)
      else $error("short press did not wake from light sleep");
   chk_sw_poweroff: assert property ( // RULE_02
      (state_q == ST_WORK && sw_any) |=> seq_pd_done)
      else $error("switch press did not reach soft-off");
   chk_core_wake: assert property ( // RULE_03
      (state_q == ST_OFF && (core_wake || press_short)) |=> seq_boot_done)
      else $error("core wake source did not boot from soft-off");
   chk_therm_off: assert property ( // RULE_04
      (state_q == ST_OFF && !wake_s5) |=> state_q == ST_OFF)
      else $error("soft-off left without a valid wake source");
   chk_therm_s34: assert property ( // RULE_04
      (state_q == ST_S34 && therm_wake) |=> (state_q == ST_PWRUP && boot_mode_out != BOOT_COLD))
      else $error("thermal event did not resume from suspend");
   chk_light_deep: assert property ( // RULE_05
      (deep && light_wake && !wake_s34) |=> $stable(state_q))
      else $error("light wake source acted in deep sleep");
   chk_hsbus_ignored: assert property ( // RULE_06
      (state_q inside {ST_S1, ST_S2} && hs_bus_act && !wake_s12) |=> !wake_evt_out)
      else $error("serial bus activity woke the system");
   chk_stop_grant: assert property ( // RULE_07
      state_q == ST_S1 |-> (cpu_stop_grant_out && !cpu_clk_stop_out && main_pwr_en_out))
      else $error("processor not in stop grant during S1");
   chk_clk_stop: assert property ( // RULE_08
      state_q == ST_S2 |-> (cpu_clk_stop_out && !cpu_stop_grant_out && main_pwr_en_out))
      else $error("processor clock not stopped during S2");
   chk_no_s3: assert property ( // RULE_09
      (refuse) |=> (state_q == ST_WORK && sleep_refused_out))
      else $error("unsupported sleep target was entered");
   chk_resume_src: assert property ( // RULE_10
      (state_q == ST_S34 && wake_s34) |=> boot_mode_out == ($past(pf_q) ? BOOT_DISK : BOOT_RAM))
      else $error("resume context source wrong");
   chk_cold_boot: assert property ( // RULE_11
      (state_q == ST_OFF && wake_s5) |=> (boot_mode_out == BOOT_COLD && !por_n_out))
      else $error("soft-off exit without cold boot reset");
   chk_wake_power: assert property ( // RULE_12
      deep |-> (!main_pwr_en_out && wake_pwr_en_out))
      else $error("device power left on in deep sleep");
   chk_os_off: assert property ( // RULE_13
      (state_q == ST_WORK && os_off) |=> seq_pd_done)
      else $error("OS soft-off request not honoured");

   // Each wake class is checked on its own in S1 and S2, since one shared term would hide a missing source
   chk_core_light: assert property ( // RULE_03
      (state_q inside {ST_S1, ST_S2} && core_wake) |=> state_q == ST_WORK)
      else $error("core wake source did not wake from light sleep");
   chk_therm_light: assert property ( // RULE_04
      (state_q inside {ST_S1, ST_S2} && therm_wake) |=> state_q == ST_WORK)
      else $error("thermal event did not wake from light sleep");
   chk_light_wake: assert property ( // RULE_05
      (state_q inside {ST_S1, ST_S2} && light_wake) |=> state_q == ST_WORK)
      else $error("light wake source did not wake from light sleep");
   chk_wake_pulse: assert property ( // RULE_01
      (state_q inside {ST_S1, ST_S2} && wake_s12) |=> seq_light_exit)
      else $error("light sleep exit without wake event");
   chk_hsbus_off: assert property ( // RULE_06
      (state_q == ST_OFF && hs_bus_act && !wake_s5) |=> state_q == ST_OFF)
      else $error("serial bus activity left soft-off");

   // A long hold must act while the switch is still down
   chk_long_off: assert property ( // RULE_02
      (state_q == ST_WORK && press_long) |=> state_q == ST_PWRDN)
      else $error("long press did not start power-down");
   // Reset stays low for the whole power-up phase, not only at its start
   chk_por_hold: assert property ( // RULE_11
      state_q == ST_PWRUP |-> (!por_n_out && main_pwr_en_out))
      else $error("power-on reset released early");
   chk_s34_refused: assert property ( // RULE_09
      (state_q == ST_WORK && req_rise && req_type == REQ_S34 && !sw_any && !os_off) |=> state_q == ST_WORK)
      else $error("suspend to RAM request was honoured");
endmodule : swps_seq

// file: verif/swps_partner.sv
/*
 Far-side model of the sequencer: front-panel switch, wake sources and
 the operating system's sleep and soft-off requests.
 Assumes the bench calls its tasks and that pins move just after a rising edge.
*/
`timescale 1ns/10ps
module swps_partner import swps_pkg::*; (
   // Clock
   input wire logic core_clk_in,
   // Pins toward the sequencer
   output logic pwr_sw_n_out,
   output logic [9:0] wake_out,
   output logic os_sleep_req_out,
   output logic [1:0] os_sleep_type_out,
   output logic os_soft_off_out,
   output logic pwr_fail_out
);
   initial begin
      pwr_sw_n_out = 1'b1;
      wake_out = 10'h000;
      os_sleep_req_out = 1'b0;
      os_sleep_type_out = 2'h0;
      os_soft_off_out = 1'b0;
      pwr_fail_out = 1'b0;
   end
   // Clean press; bounce is left to the glitch scenario
   task automatic press(input int cyc);
      @(posedge core_clk_in);
      pwr_sw_n_out <= 1'b0;
      repeat (cyc) @(posedge core_clk_in);
      pwr_sw_n_out <= 1'b1;
   endtask : press
   task automatic hold_sw(input logic down);
      @(posedge core_clk_in);
      pwr_sw_n_out <= ~down;
   endtask : hold_sw
   // Held past the two-flop sync so the level is never missed
   task automatic wake(input int idx);
      @(posedge core_clk_in);
      wake_out[idx] <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      wake_out[idx] <= 1'b0;
   endtask : wake
   // Type rises together with the request and is held with it
   task automatic sleep(input logic [1:0] typ);
      @(posedge core_clk_in);
      os_sleep_type_out <= typ;
      os_sleep_req_out <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      os_sleep_req_out <= 1'b0;
   endtask : sleep
   task automatic soft_off();
      @(posedge core_clk_in);
      os_soft_off_out <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      os_soft_off_out <= 1'b0;
   endtask : soft_off
endmodule : swps_partner

// file: verif/swps_seq_tb.sv
/*
 Self-checking bench for the sleep/wake power sequencer.
 Assumes a shortened tick (10 cycles) so the four-second hold fits the run.
*/
`timescale 1ns/10ps
module swps_seq_tb import swps_pkg::*; ();
   localparam int TICKS = 10;
   localparam int DEB_CYC = DEB_TICKS * TICKS;
   localparam int HOLD_CYC = HOLD_TICKS * TICKS;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic pwr_sw_n;
   logic [9:0] wake;
   logic os_req;
   logic [1:0] os_type;
   logic os_off;
   logic pwr_fail;
   logic main_pwr;
   logic wake_pwr;
   logic por_n;
   logic stop_grant;
   logic clk_stop;
   logic [1:0] glb;
   logic [2:0] slp;
   logic [1:0] boot;
   logic wake_evt;
   logic refused;
   int n_errors = 0;
   int comparisons = 0;
   int n_wake = 0;
   int n_ref = 0;
   int el;
   int w0;

   always #5 core_clk_in = ~core_clk_in;

   swps_partner u_pt (.core_clk_in(core_clk_in), .pwr_sw_n_out(pwr_sw_n), .wake_out(wake),
      .os_sleep_req_out(os_req), .os_sleep_type_out(os_type), .os_soft_off_out(os_off),
      .pwr_fail_out(pwr_fail));

   swps_seq #(.TICK_CYC_P(TICKS)) u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .pwr_sw_n_in(pwr_sw_n), .rtc_alarm_in(wake[P_RTC]), .lan_wake_in(wake[P_LAN]),
      .modem_wake_in(wake[P_MODEM]), .thermal_in(wake[P_THERM]), .ir_wake_in(wake[P_IR]),
      .voice_wake_in(wake[P_VOICE]), .usb_wake_in(wake[P_USB]), .kbd_wake_in(wake[P_KBD]),
      .mouse_wake_in(wake[P_MOUSE]), .hs_bus_act_in(wake[P_HSBUS]), .os_sleep_req_in(os_req),
      .os_sleep_type_in(os_type), .os_soft_off_in(os_off), .pwr_fail_in(pwr_fail),
      .main_pwr_en_out(main_pwr), .wake_pwr_en_out(wake_pwr), .por_n_out(por_n),
      .cpu_stop_grant_out(stop_grant), .cpu_clk_stop_out(clk_stop), .global_state_out(glb),
      .sleep_state_out(slp), .boot_mode_out(boot), .wake_evt_out(wake_evt),
      .sleep_refused_out(refused));

   // Pulses last one cycle, so they are counted rather than polled
   always @(posedge core_clk_in) begin
      if (wake_evt === 1'b1) n_wake++;
      if (refused === 1'b1) n_ref++;
   end

   task automatic stop_test();
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Bounded wait for a state; a timeout ends the run
   task automatic wait_state(input logic [1:0] g, input logic [2:0] s, input logic p, input int lim,
                             output int n);
      n = 0;
      #1;
      while (!(glb === g && slp === s && por_n === p)) begin
         @(posedge core_clk_in);
         #1;
         n++;
         if (n > lim) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, {glb, slp, por_n}, {g, s, p});
            stop_test();
         end
      end
      comparisons++;
   endtask : wait_state

   task automatic t_reset();
      #1;
      check(main_pwr, 1'b0);
      check(wake_pwr, 1'b1);
      check(por_n, 1'b0);
      check({stop_grant, clk_stop}, 2'h0);
      check({glb, slp, boot}, {GLB_G2, SLP_S5, BOOT_COLD});
      $display("test reset done");
   endtask : t_reset

   task automatic t_cold_rtc();
      w0 = n_wake;
      u_pt.wake(P_RTC);
      wait_state(GLB_G0, SLP_S0, 1'b0, 20, el);
      check(main_pwr, 1'b1);
      check(boot, BOOT_COLD);
      check(n_wake, w0 + 1);
      wait_state(GLB_G0, SLP_S0, 1'b1, POR_CYC + 20, el);
      $display("test cold_rtc done");
   endtask : t_cold_rtc

   task automatic t_refuse();
      logic [1:0] typ;
      for (int k = 0; k < 2; k++) begin
         typ = (k == 0) ? REQ_S34 : 2'h0;
         w0 = n_ref;
         u_pt.sleep(typ);
         repeat (6) @(posedge core_clk_in);
         check(n_ref, w0 + 1);
         check({glb, slp}, {GLB_G0, SLP_S0});
      end
      $display("test refuse done");
   endtask : t_refuse

   // Every wake pin from S1 or S2, with serial bus activity tried first
   task automatic t_sleep_wakes();
      logic [1:0] typ;
      for (int i = P_RTC; i <= P_MOUSE; i++) begin
         typ = (i % 2 == 0) ? REQ_S1 : REQ_S2;
         u_pt.sleep(typ);
         wait_state(GLB_G1, {1'b0, typ}, 1'b1, 20, el);
         check(stop_grant, typ == REQ_S1);
         check(clk_stop, typ == REQ_S2);
         u_pt.wake(P_HSBUS);
         repeat (5) @(posedge core_clk_in);
         check(slp, {1'b0, typ});
         u_pt.wake(i);
         wait_state(GLB_G0, SLP_S0, 1'b1, 20, el);
         check({stop_grant, clk_stop}, 2'h0);
      end
      $display("test sleep_wakes done");
   endtask : t_sleep_wakes

   task automatic t_switch_sleep();
      u_pt.sleep(REQ_S1);
      u_pt.press(DEB_CYC / 4);
      repeat (DEB_CYC * 2) @(posedge core_clk_in);
      check(slp, SLP_S1);
      w0 = n_wake;
      u_pt.press(DEB_CYC + 100);
      wait_state(GLB_G0, SLP_S0, 1'b1, DEB_CYC * 3, el);
      // The wake pulse is counted at the edge after the state change
      @(posedge core_clk_in);
      #1;
      check(n_wake, w0 + 1);
      $display("test switch_sleep done");
   endtask : t_switch_sleep

   task automatic t_press_off();
      u_pt.press(DEB_CYC + 100);
      wait_state(GLB_G2, SLP_S0, 1'b1, DEB_CYC * 3, el);
      wait_state(GLB_G2, SLP_S5, 1'b0, PD_CYC + 20, el);
      check({main_pwr, wake_pwr}, 2'h1);
      for (int i = P_THERM; i <= P_HSBUS; i++) begin
         u_pt.wake(i);
         repeat (5) @(posedge core_clk_in);
         check({glb, slp}, {GLB_G2, SLP_S5});
      end
      u_pt.press(DEB_CYC + 100);
      wait_state(GLB_G0, SLP_S0, 1'b0, DEB_CYC * 3, el);
      check(boot, BOOT_COLD);
      wait_state(GLB_G0, SLP_S0, 1'b1, POR_CYC + 20, el);
      $display("test press_off done");
   endtask : t_press_off

   task automatic t_os_off();
      u_pt.soft_off();
      wait_state(GLB_G2, SLP_S5, 1'b0, PD_CYC + 20, el);
      check(main_pwr, 1'b0);
      u_pt.wake(P_MODEM);
      wait_state(GLB_G0, SLP_S0, 1'b1, POR_CYC + 20, el);
      $display("test os_off done");
   endtask : t_os_off

   // Long hold acts at the threshold while the switch is still down
   task automatic t_long();
      u_pt.hold_sw(1'b1);
      wait_state(GLB_G2, SLP_S0, 1'b1, HOLD_CYC + DEB_CYC + 50, el);
      check(el >= HOLD_CYC, 1'b1);
      check(main_pwr, 1'b1);
      wait_state(GLB_G2, SLP_S5, 1'b0, PD_CYC + 20, el);
      u_pt.hold_sw(1'b0);
      repeat (DEB_CYC * 2) @(posedge core_clk_in);
      check({glb, slp}, {GLB_G2, SLP_S5});
      $display("test long done");
   endtask : t_long

   initial begin
      // Flops only take reset at a clock edge, since the initial low gives no falling edge
      repeat (8) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_cold_rtc();
      t_refuse();
      t_sleep_wakes();
      t_switch_sleep();
      t_press_off();
      t_os_off();
      t_long();
      stop_test();
   end
endmodule : swps_seq_tb
